/* rtl/wdw_pkg.sv */
// Summary of operation
// - Port A fall, interrupt, or overflow wakes
// - Halt enters low power, sets power-down flag
// - Power-up or clear-watchdog clears power-down flag
// - Overflow asleep sets expiry, resets PC/stack only
// - Per-pin wake enables; resume after halt
// - Masked or stack-full wake resumes, stays pending
// - Enabled interrupt with free stack gets serviced
// - Flag pending before halt cannot wake
// - Watchdog counts slow oscillator ticks
// - Period field selects 2^(8+n) ticks
// - Key 01010 enables, 10101 disables, else reset
// - Bad key sets key reset flag bit 0
// - Key reset flag cleared only by power-up or software zero
// - Power-on key 01010, period 011
// - Awake time-out resets device, sets expiry flag
// - Bad key, clear-watchdog or halt clears count
// - Halt clears count; disabled watchdog stays stopped
// - Idle enables both zero gives sleep
package wdw_pkg;

    localparam logic [11:0] WDW_CTRL_ADDR = 12'h000;
    localparam logic [11:0] WDW_RSTF_ADDR = 12'h004;
    localparam logic [11:0] WDW_STAT_ADDR = 12'h008;
    localparam logic [11:0] WDW_WAKE_ADDR = 12'h00C;

    localparam logic [7:0] WDW_CTRL_RESET = 8'h53;
    localparam logic [4:0] WDW_KEY_ENABLE = 5'h0A;
    localparam logic [4:0] WDW_KEY_DISABLE = 5'h15;
    localparam int WDW_KEY_LSB = 3;
    localparam int WDW_PERIOD_BASE = 8;
    localparam int WDW_CNT_W = 16;

    localparam int WDW_CLK_HZ = 25000000;
    localparam int WDW_SRESET_US = 10;
    localparam int WDW_SRESET_CYC = (WDW_SRESET_US * (WDW_CLK_HZ / 1000000) > 0)
        ? WDW_SRESET_US * (WDW_CLK_HZ / 1000000) : 1;
    localparam int WDW_PULSE_CYC = 4;

    typedef enum logic [1:0]
    {
        WDW_RUN = 2'b00,
        WDW_SLEEP = 2'b01,
        WDW_IDLE = 2'b10
    } wdw_mode_e;

    typedef struct packed
    {
        logic [4:0] key;
        logic [2:0] period;
    } wdw_ctrl_s;

endpackage

/* rtl/wdw_sync.sv */
`timescale 1ns/10ps
module wdw_sync
    import wdw_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] lvl_ff;
    logic [WIDTH-1:0] nxt_lvl;

    // Change accepted only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            lvl_ff <= '1;
        end
        else
        begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level_o = lvl_ff;
    assign fall_o = lvl_ff & ~nxt_lvl;
endmodule

/* rtl/wdw_top.sv */
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
module wdw_top
    import wdw_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int SRESET_CYC = WDW_SRESET_CYC
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic slow_osc_clock_i,
    input wire logic halt_instr_i,
    input wire logic clear_watchdog_instr_i,
    input wire logic fast_clock_idle_enable_i,
    input wire logic sub_clock_idle_enable_i,
    input wire logic [PORT_W-1:0] port_a_i,
    input wire logic irq_req_i,
    input wire logic irq_enabled_i,
    input wire logic stack_full_i,
    output logic wake_o,
    output logic irq_service_o,
    output logic pc_sp_reset_o,
    output logic device_reset_o,
    output logic sleep_o,
    output logic idle_o,
    output logic power_down_flag_o,
    output logic watchdog_expiry_flag_o
);
    wdw_ctrl_s ctrl_ff;
    logic [PORT_W-1:0] port_a_wake_enable_ff;
    logic watchdog_key_reset_flag_ff;
    logic power_down_flag_ff;
    logic watchdog_expiry_flag_ff;
    wdw_mode_e mode_ff;
    wdw_mode_e nxt_mode;
    logic [WDW_CNT_W-1:0] cnt_ff;
    logic [31:0] sreset_cnt_ff;
    logic sreset_pend_ff;
    logic irq_block_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wake_ff;
    logic irq_service_ff;
    logic pc_sp_reset_ff;
    logic device_reset_ff;
    logic [2:0] rst_pulse_ff;
    logic sleep_ff;
    logic idle_ff;
    logic [PORT_W-1:0] pin_wake;

    logic [PORT_W-1:0] port_lvl;
    logic [PORT_W-1:0] port_fall;
    logic [0:0] osc_lvl;
    logic [0:0] osc_fall;

    // Slow oscillator is asynchronous; sampled through the same filter
    // Filters reset high, the idle level, so no false fall follows reset
    wdw_sync #(.WIDTH(PORT_W)) u_port_sync
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(port_a_i),
        .level_o(port_lvl),
        .fall_o(port_fall)
    );

    wdw_sync #(.WIDTH(1)) u_osc_sync
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(slow_osc_clock_i),
        .level_o(osc_lvl),
        .fall_o(osc_fall)
    );

    // APB decode
    wire apb_acc = psel_i & penable_i & ~pready_ff;
    wire apb_wr = apb_acc & pwrite_i;
    wire hit_ctrl = (paddr_i == WDW_CTRL_ADDR);
    wire hit_rstf = (paddr_i == WDW_RSTF_ADDR);
    wire hit_stat = (paddr_i == WDW_STAT_ADDR);
    wire hit_wake = (paddr_i == WDW_WAKE_ADDR);
    wire hit_any = hit_ctrl | hit_rstf | hit_stat | hit_wake;
    wire wr_ctrl = apb_wr & hit_ctrl;
    wire wr_rstf = apb_wr & hit_rstf;
    wire wr_wake = apb_wr & hit_wake;

    // Unused bits read as zero
    wire [31:0] rd_data = hit_ctrl ? {24'h000000, ctrl_ff}
        : hit_rstf ? {31'h00000000, watchdog_key_reset_flag_ff}
        : hit_stat ? {28'h0000000, mode_ff, watchdog_expiry_flag_ff, power_down_flag_ff}
        : hit_wake ? 32'(port_a_wake_enable_ff)
        : 32'h00000000;

    // Key decode
    wire key_en = (ctrl_ff.key == WDW_KEY_ENABLE);
    wire key_dis = (ctrl_ff.key == WDW_KEY_DISABLE);
    wire key_bad = ~key_en & ~key_dis;
    wire asleep = (mode_ff != WDW_RUN);
    // Halt is accepted only while running
    wire halt_go = (mode_ff == WDW_RUN) & halt_instr_i;

    // Time-out compare
    // Fires on the tick that would reach the limit, so a period is 2^(8+n) ticks
    wire [WDW_CNT_W-1:0] limit = WDW_CNT_W'(1) << (WDW_PERIOD_BASE + 32'(ctrl_ff.period));
    wire tick = osc_fall[0] & key_en;
    wire overflow = tick & (cnt_ff >= limit - WDW_CNT_W'(1));
    wire cnt_clear = halt_instr_i | clear_watchdog_instr_i | sreset_pend_ff | overflow;

    // Wake sources; each pin qualified by its own enable
    genvar p;
    generate
        for (p = 0; p < PORT_W; p++)
        begin : g_pin
            assign pin_wake[p] = port_fall[p] & port_a_wake_enable_ff[p];
        end
    endgenerate

    wire port_wake = |pin_wake;
    wire irq_wake = irq_req_i & ~irq_block_ff;
    wire wake_evt = asleep & (port_wake | irq_wake | overflow);
    wire sreset_done = sreset_pend_ff & (sreset_cnt_ff >= 32'(SRESET_CYC - 1));

    // Interrupt is taken at once only if the core can stack it
    wire irq_ready = irq_enabled_i & ~stack_full_i;
    // Overflow resets the device awake, only PC and stack asleep
    wire ovf_awake = overflow & ~asleep;
    wire ovf_asleep = overflow & asleep;

    always_comb
    begin
        nxt_mode = mode_ff;
        if (halt_go)
        begin
            // Both idle enables low gives sleep
            if (!fast_clock_idle_enable_i && !sub_clock_idle_enable_i)
                nxt_mode = WDW_SLEEP;
            else
                nxt_mode = WDW_IDLE;
        end
        else if (wake_evt)
        begin
            nxt_mode = WDW_RUN;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl_ff <= WDW_CTRL_RESET;
            port_a_wake_enable_ff <= '0;
        end
        // Soft reset restores the power-on value
        else if (sreset_done)
        begin
            ctrl_ff <= WDW_CTRL_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= pwdata_i[7:0];
            if (wr_wake)
                port_a_wake_enable_ff <= pwdata_i[PORT_W-1:0];
        end
    end

    // Set beats software clear
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            watchdog_key_reset_flag_ff <= 1'b0;
        else if (sreset_done)
            watchdog_key_reset_flag_ff <= 1'b1;
        else if (wr_rstf && !pwdata_i[0])
            watchdog_key_reset_flag_ff <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            power_down_flag_ff <= 1'b0;
        // Halt wins over a clear in the same cycle
        else if (halt_go)
            power_down_flag_ff <= 1'b1;
        else if (clear_watchdog_instr_i)
            power_down_flag_ff <= 1'b0;
    end

    // Expiry flag survives the watchdog reset it causes
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            watchdog_expiry_flag_ff <= 1'b0;
        else if (overflow)
            watchdog_expiry_flag_ff <= 1'b1;
        else if (halt_instr_i || clear_watchdog_instr_i)
            watchdog_expiry_flag_ff <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            mode_ff <= WDW_RUN;
        else
            mode_ff <= nxt_mode;
    end

    // Request already raised at halt is masked until the request drops
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            irq_block_ff <= 1'b0;
        else if (halt_go)
            irq_block_ff <= irq_req_i;
        else if (!irq_req_i)
            irq_block_ff <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cnt_ff <= '0;
        else if (cnt_clear)
            cnt_ff <= '0;
        // Disabled watchdog gates the tick, so the count holds
        else if (tick)
            cnt_ff <= cnt_ff + WDW_CNT_W'(1);
    end

    // Bad key: reset follows after the soft-reset delay
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sreset_pend_ff <= 1'b0;
            sreset_cnt_ff <= '0;
        end
        else if (sreset_done)
        begin
            sreset_pend_ff <= 1'b0;
            sreset_cnt_ff <= '0;
        end
        else if (sreset_pend_ff)
        begin
            sreset_cnt_ff <= sreset_cnt_ff + 32'd1;
        end
        else if (key_bad)
        begin
            sreset_pend_ff <= 1'b1;
        end
    end

    // Reset pulse held a few cycles so the core sees it
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rst_pulse_ff <= '0;
            device_reset_ff <= 1'b0;
        end
        else if (sreset_done || ovf_awake)
        begin
            rst_pulse_ff <= 3'(WDW_PULSE_CYC - 1);
            device_reset_ff <= 1'b1;
        end
        else if (rst_pulse_ff != 3'd0)
        begin
            rst_pulse_ff <= rst_pulse_ff - 3'd1;
        end
        else
        begin
            device_reset_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wake_ff <= 1'b0;
            irq_service_ff <= 1'b0;
            pc_sp_reset_ff <= 1'b0;
        end
        else
        begin
            wake_ff <= wake_evt;
            irq_service_ff <= wake_evt & irq_wake & ~overflow & irq_ready;
            pc_sp_reset_ff <= ovf_asleep;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            // One wait state: ready follows the first access edge
            pready_ff <= apb_acc;
            pslverr_ff <= apb_acc & ~hit_any;
            prdata_ff <= (apb_acc & ~pwrite_i) ? rd_data : 32'h00000000;
        end
    end

    // Decoded from the next mode so these outputs come from flops
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sleep_ff <= 1'b0;
            idle_ff <= 1'b0;
        end
        else
        begin
            sleep_ff <= (nxt_mode == WDW_SLEEP);
            idle_ff <= (nxt_mode == WDW_IDLE);
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign wake_o = wake_ff;
    assign irq_service_o = irq_service_ff;
    assign pc_sp_reset_o = pc_sp_reset_ff;
    assign device_reset_o = device_reset_ff;
    assign sleep_o = sleep_ff;
    assign idle_o = idle_ff;
    assign power_down_flag_o = power_down_flag_ff;
    assign watchdog_expiry_flag_o = watchdog_expiry_flag_ff;
endmodule

/* bench/wdw_props.sv */
`timescale 1ns/10ps
module wdw_props
    import wdw_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic halt_instr_i,
    input wire logic clear_watchdog_instr_i,
    input wire logic fast_clock_idle_enable_i,
    input wire logic sub_clock_idle_enable_i,
    input wire logic wake_o,
    input wire logic irq_service_o,
    input wire logic pc_sp_reset_o,
    input wire logic device_reset_o,
    input wire logic sleep_o,
    input wire logic idle_o,
    input wire logic power_down_flag_o,
    input wire logic watchdog_expiry_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic idle_sel = fast_clock_idle_enable_i || sub_clock_idle_enable_i;
    sequence s_rst4; device_reset_o[*4] ##1 !device_reset_o; endsequence
    property p_halt_pd; halt_instr_i |=> power_down_flag_o; endproperty
    a_halt_pd: assert property (p_halt_pd) else $error("flag low after halt");
    property p_clr_pd; clear_watchdog_instr_i && !halt_instr_i |=> !power_down_flag_o; endproperty
    a_clr_pd: assert property (p_clr_pd) else $error("flag kept");
    property p_sleep; halt_instr_i && !idle_sel |=> sleep_o && !idle_o; endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_idle; halt_instr_i && idle_sel |=> idle_o && !sleep_o; endproperty
    a_idle: assert property (p_idle) else $error("no idle");
    property p_wake_run; wake_o |-> !sleep_o && !idle_o; endproperty
    a_wake_run: assert property (p_wake_run) else $error("still low power");
    property p_ovf; pc_sp_reset_o |-> wake_o && !device_reset_o ##[0:1] watchdog_expiry_flag_o;
    endproperty
    a_ovf: assert property (p_ovf) else $error("bad overflow wake");
    property p_svc; irq_service_o |-> wake_o && !pc_sp_reset_o; endproperty
    a_svc: assert property (p_svc) else $error("service without wake");
    property p_rst; $rose(device_reset_o) |-> s_rst4; endproperty
    a_rst: assert property (p_rst) else $error("reset length");
    property p_rdy; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err; pslverr_o |-> pready_o; endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule

/* bench/wdw_core_model.sv */
`timescale 1ns/10ps
module wdw_core_model
    import wdw_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic halt_cmd_i,
    input wire logic clear_cmd_i,
    input wire logic asleep_i,
    output logic halt_instr_o,
    output logic clear_watchdog_instr_o
);
    // Stopped core issues nothing until woken
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            halt_instr_o <= 1'b0;
            clear_watchdog_instr_o <= 1'b0;
        end
        else
        begin
            halt_instr_o <= halt_cmd_i && !asleep_i;
            clear_watchdog_instr_o <= clear_cmd_i && !asleep_i;
        end
    end
endmodule

/* bench/watchdog_and_wakeup_control_bench.sv */
`timescale 1ns/10ps
module watchdog_and_wakeup_control_bench;
    import wdw_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic slow_osc_clock_i = 1'b0, fast_clock_idle_enable_i = 1'b0, sub_clock_idle_enable_i = 1'b0;
    logic [7:0] port_a_i = 8'hFF;
    logic irq_req_i = 1'b0, irq_enabled_i = 1'b0, stack_full_i = 1'b0, halt_cmd = 1'b0;
    logic clr_cmd = 1'b0, err, halt_instr_i, clear_watchdog_instr_i, pready_o, pslverr_o;
    logic wake_o, irq_service_o, pc_sp_reset_o, device_reset_o, sleep_o, idle_o;
    logic power_down_flag_o, watchdog_expiry_flag_o;
    logic [2:0] div = 3'h0;
    int num_errors = 0, samples_checked = 0, wait_n = 0;
    wire logic [3:0] ev = {device_reset_o, pc_sp_reset_o, irq_service_o, wake_o};
    logic [11:0] r_addr [4] = '{WDW_WAKE_ADDR, WDW_CTRL_ADDR, WDW_STAT_ADDR, 12'h010};
    logic [31:0] r_wd [4] = '{32'h5, 32'hA8, 32'hFF, 32'h5A};
    logic [31:0] r_rd [4] = '{32'h5, 32'hA8, 32'h0, 32'h0};
    logic r_err [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    always #20 clk_i = ~clk_i;
    // Slow tick every 8 clocks keeps long periods short
    always @(posedge clk_i) div <= div + 3'h1;
    always @(posedge clk_i) slow_osc_clock_i <= div[2];

    wdw_top #(.PORT_W(8), .SRESET_CYC(4)) u_wdw_top (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .slow_osc_clock_i(slow_osc_clock_i), .halt_instr_i(halt_instr_i),
        .clear_watchdog_instr_i(clear_watchdog_instr_i),
        .fast_clock_idle_enable_i(fast_clock_idle_enable_i),
        .sub_clock_idle_enable_i(sub_clock_idle_enable_i), .port_a_i(port_a_i),
        .irq_req_i(irq_req_i), .irq_enabled_i(irq_enabled_i), .stack_full_i(stack_full_i),
        .wake_o(wake_o), .irq_service_o(irq_service_o), .pc_sp_reset_o(pc_sp_reset_o),
        .device_reset_o(device_reset_o), .sleep_o(sleep_o), .idle_o(idle_o),
        .power_down_flag_o(power_down_flag_o),
        .watchdog_expiry_flag_o(watchdog_expiry_flag_o));
    wdw_core_model u_wdw_core_model (.clk_i(clk_i), .reset_i(reset_i), .halt_cmd_i(halt_cmd),
        .clear_cmd_i(clr_cmd), .asleep_i(sleep_o | idle_o), .halt_instr_o(halt_instr_i),
        .clear_watchdog_instr_o(clear_watchdog_instr_i));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task instr(input logic h);
        @(posedge clk_i);
        halt_cmd <= h;
        clr_cmd <= !h;
        @(posedge clk_i);
        halt_cmd <= 1'b0;
        clr_cmd <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task wait_ev(input int i);
        int n;
        n = 0;
        while (ev[i] !== 1'b1 && n < 5000)
        begin
            @(posedge clk_i);
            n++;
        end
        wait_n = n;
        chk({31'h0, ev[i]}, 32'h1);
    endtask

    task give_verdict;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #800000;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(WDW_CTRL_ADDR, 32'h53);
        rdchk(WDW_RSTF_ADDR, 32'h0);
        rdchk(WDW_STAT_ADDR, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, r_addr[i], r_wd[i]);
            chk({31'h0, err}, {31'h0, r_err[i]});
            rdchk(r_addr[i], r_rd[i]);
        end
        instr(1'b1);
        rdchk(WDW_STAT_ADDR, 32'h5);
        port_a_i <= 8'hFD;
        repeat (8) @(posedge clk_i);
        chk({31'h0, sleep_o}, 32'h1);
        port_a_i <= 8'hFC;
        wait_ev(0);
        rdchk(WDW_STAT_ADDR, 32'h1);
        instr(1'b0);
        rdchk(WDW_STAT_ADDR, 32'h0);
        fast_clock_idle_enable_i <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            instr(1'b1);
            chk({31'h0, idle_o}, 32'h1);
            chk({31'h0, power_down_flag_o}, 32'h1);
            irq_enabled_i <= (k != 1);
            stack_full_i <= (k == 2);
            irq_req_i <= 1'b1;
            wait_ev(0);
            chk({31'h0, ev[1]}, {31'h0, k == 0});
            irq_req_i <= 1'b0;
        end
        @(posedge clk_i);
        stack_full_i <= 1'b0;
        fast_clock_idle_enable_i <= 1'b0;
        sub_clock_idle_enable_i <= 1'b1;
        irq_req_i <= 1'b1;
        instr(1'b1);
        chk({31'h0, idle_o}, 32'h1);
        apb(1'b1, WDW_CTRL_ADDR, 32'h50);
        wait_ev(2);
        chk({31'h0, watchdog_expiry_flag_o}, 32'h1);
        rdchk(WDW_STAT_ADDR, 32'h3);
        irq_req_i <= 1'b0;
        instr(1'b0);
        wait_ev(3);
        chk({31'h0, wait_n > 2000 && wait_n < 2100}, 32'h1);
        rdchk(WDW_STAT_ADDR, 32'h2);
        apb(1'b1, WDW_CTRL_ADDR, 32'h3);
        wait_ev(3);
        rdchk(WDW_RSTF_ADDR, 32'h1);
        rdchk(WDW_CTRL_ADDR, 32'h53);
        apb(1'b1, WDW_RSTF_ADDR, 32'h1);
        rdchk(WDW_RSTF_ADDR, 32'h1);
        apb(1'b1, WDW_RSTF_ADDR, 32'h0);
        rdchk(WDW_RSTF_ADDR, 32'h0);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(WDW_STAT_ADDR, 32'h0);
        give_verdict();
    end
endmodule

bind wdw_top wdw_props u_wdw_props (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .halt_instr_i(halt_instr_i), .clear_watchdog_instr_i(clear_watchdog_instr_i),
    .fast_clock_idle_enable_i(fast_clock_idle_enable_i),
    .sub_clock_idle_enable_i(sub_clock_idle_enable_i), .wake_o(wake_o),
    .irq_service_o(irq_service_o), .pc_sp_reset_o(pc_sp_reset_o),
    .device_reset_o(device_reset_o), .sleep_o(sleep_o), .idle_o(idle_o),
    .power_down_flag_o(power_down_flag_o), .watchdog_expiry_flag_o(watchdog_expiry_flag_o));
